// ==== rtl/dual_timer_control.sv ====
// module: timer 0 and 1 counting, run and irq control, count registers
// assumes: core drives sfr bus synchronously, ack pulses come from vectoring
//
// Summary of operation
// R1: timer 1 overflow sets control bit 7
// R2: vectoring clears timer 1 overflow flag
// R3: bit 6 runs or stops timer 1
// R4: timer 0 overflow sets control bit 5
// R5: vectoring clears timer 0 overflow flag
// R6: bit 4 runs or stops timer 0
// R7: irq 1 flag bit 3, edge or level
// R8: irq 0 flag bit 1, edge or level
// R9: vectoring clears irq flag only if edge
// R10: level mode flag tracks the pin
// R11: bits 2 and 0 choose edge when set
// R12: low nibble never affects counting
// R13: high and low bytes, split or joined
// R14: all count bytes reset to zero
// R15: both timers share modes 0 to 2; mode 3 splits timer 0 but stops timer 1
// R16: timer mode counts every core clock
// R17: mode 0 is a 13-bit counter
// R18: modes 13-bit, 16-bit, reload, split/stop
// R19: count needs run and gate clear or pin high
// R20: counter counts high-then-low samples, half rate
// R21: 13-bit uses low five low-byte bits
// R22: writes next clock, hardware set wins
`timescale 1ns/1ps
module dual_timer_control
	import dual_timer_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// special function register access
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWrEn,
	input  wire logic [7:0] sfrWrData,
	output logic      [7:0] sfrRdData,
	// vectoring acknowledges
	input  wire logic       ackTimer0,
	input  wire logic       ackTimer1,
	input  wire logic       ackExt0,
	input  wire logic       ackExt1,
	// pins
	input  wire logic       extIrq0Pin,
	input  wire logic       extIrq1Pin,
	input  wire logic       timer0CountPin,
	input  wire logic       timer1CountPin,
	// interrupt requests and baud tick
	output logic            timer0IrqReq,
	output logic            timer1IrqReq,
	output logic            extIrq0Req,
	output logic            extIrq1Req,
	output logic            timer1OvfPulse
);

	// control and data registers
	logic        tmr1OvfQ, tmr1RunQ, tmr0OvfQ, tmr0RunQ;
	logic        irq1EdgeQ, irq0EdgeQ;
	logic [7:0]  modeCfgQ;
	logic [7:0]  cnt0LoQ, cnt0HiQ, cnt1LoQ, cnt1HiQ;
	logic [7:0]  rdDataQ;
	logic        ovfPulseQ;
	logic [1:0]  cntPrevQ;

	// decoded and derived signals
	logic        wrCtrl, wrMode, wrLo0, wrHi0, wrLo1, wrHi1;
	logic        gate0, gate1, cnt0Sel, cnt1Sel;
	timer_mode_t mode0, mode1;
	logic        run0, run1, tick0, tick1, hiTick0;
	logic [1:0]  cntFall;
	count_step_t step0, step1;
	logic        ovfEv0, ovfEv1, hiOvf0, tmr1FlagSet;
	logic        irq0Flag, irq1Flag;
	timer_pins_if #(.WIDTH(PIN_COUNT)) pinBus ();

	// one counting step for the given mode
	function automatic count_step_t stepCount(
		input timer_mode_t m,
		input logic [7:0]  hi,
		input logic [7:0]  lo
	);
		count_step_t r;
		logic [13:0] s13;
		logic [16:0] s16;
		r   = '{ovf: 1'h0, hi: hi, lo: lo};
		s13 = {1'h0, hi, lo[PRESCALE_BITS-1:0]} + 14'h0001;
		s16 = {1'h0, hi, lo} + 17'h0_0001;
		case (m)
			// R17 R21 thirteen bits, upper low-byte bits untouched
			MODE_13BIT: begin
				r.ovf = s13[13];
				r.hi  = s13[12:PRESCALE_BITS];
				r.lo  = {lo[7:PRESCALE_BITS], s13[PRESCALE_BITS-1:0]};
			end
			MODE_16BIT: begin
				r.ovf = s16[16];
				r.hi  = s16[15:8];
				r.lo  = s16[7:0];
			end
			// R18 reload low from high
			MODE_RELOAD8: begin
				r.ovf = (lo == BYTE_FULL);
				r.lo  = r.ovf ? hi : lo + 8'h01;
			end
			MODE_SPLIT: begin
				r.ovf = (lo == BYTE_FULL);
				r.lo  = lo + 8'h01;
			end
			default: r = '{ovf: 1'h0, hi: hi, lo: lo};
		endcase
		return r;
	endfunction

	// pin filter, shared by interrupt and count inputs
	pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
		.clk    (clk),
		.rst    (rst),
		.pinRaw ({timer1CountPin, timer0CountPin, extIrq1Pin, extIrq0Pin}),
		.pins   (pinBus.source)
	);

	// address decode
	assign wrCtrl = sfrWrEn && (sfrAddr == ADDR_RUN_IRQ_CTRL);
	assign wrMode = sfrWrEn && (sfrAddr == ADDR_MODE_CONFIG);
	assign wrLo0  = sfrWrEn && (sfrAddr == ADDR_TMR0_LOW);
	assign wrHi0  = sfrWrEn && (sfrAddr == ADDR_TMR0_HIGH);
	assign wrLo1  = sfrWrEn && (sfrAddr == ADDR_TMR1_LOW);
	assign wrHi1  = sfrWrEn && (sfrAddr == ADDR_TMR1_HIGH);

	// R15 same field layout per timer
	assign gate0   = modeCfgQ[CFG_TMR0_BASE + CFG_GATE_OFS];
	assign gate1   = modeCfgQ[CFG_TMR1_BASE + CFG_GATE_OFS];
	assign cnt0Sel = modeCfgQ[CFG_TMR0_BASE + CFG_COUNTER_OFS];
	assign cnt1Sel = modeCfgQ[CFG_TMR1_BASE + CFG_COUNTER_OFS];
	assign mode0   = timer_mode_t'(modeCfgQ[CFG_TMR0_BASE + CFG_MODE_OFS +: 2]);
	assign mode1   = timer_mode_t'(modeCfgQ[CFG_TMR1_BASE + CFG_MODE_OFS +: 2]);

	// R19 R12 run gating ignores irq flag and edge bits
	assign run0 = tmr0RunQ & (~gate0 | pinBus.level[PIN_IRQ0]);
	assign run1 = tmr1RunQ & (~gate1 | pinBus.level[PIN_IRQ1]);
	// R20 high sample then low sample
	assign cntFall = cntPrevQ & ~{pinBus.level[PIN_CNT1], pinBus.level[PIN_CNT0]};

	// R16 timer mode ticks every clock, no prescaler
	assign tick0 = run0 & (cnt0Sel ? cntFall[0] : 1'h1);
	// R18 timer 1 holds in split mode
	assign tick1 = run1 & (mode1 != MODE_SPLIT) & (cnt1Sel ? cntFall[1] : 1'h1);
	// R18 split high byte: timer only, on timer 1 run
	assign hiTick0 = (mode0 == MODE_SPLIT) & tmr1RunQ;

	assign step0  = stepCount(mode0, cnt0HiQ, cnt0LoQ);
	assign step1  = stepCount(mode1, cnt1HiQ, cnt1LoQ);
	assign ovfEv0 = tick0 & step0.ovf;
	assign ovfEv1 = tick1 & step1.ovf;
	assign hiOvf0 = hiTick0 & (cnt0HiQ == BYTE_FULL);
	// split high byte takes over the timer 1 flag
	assign tmr1FlagSet = (mode0 == MODE_SPLIT) ? hiOvf0 : ovfEv1;

	// previous count pin samples
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cntPrevQ <= 2'h3;
		else cntPrevQ <= {pinBus.level[PIN_CNT1], pinBus.level[PIN_CNT0]};
	end

	// mode configuration
	always_ff @(posedge clk or posedge rst) begin
		if (rst) modeCfgQ <= BYTE_RESET;
		else if (wrMode) modeCfgQ <= sfrWrData;
	end

	// R3 R6 run bits, software only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tmr1RunQ <= 1'h0;
			tmr0RunQ <= 1'h0;
		end else if (wrCtrl) begin
			tmr1RunQ <= sfrWrData[TMR1_RUN_BIT];
			tmr0RunQ <= sfrWrData[TMR0_RUN_BIT];
		end
	end

	// R11 trigger type bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq1EdgeQ <= 1'h0;
			irq0EdgeQ <= 1'h0;
		end else if (wrCtrl) begin
			irq1EdgeQ <= sfrWrData[IRQ1_EDGE_BIT];
			irq0EdgeQ <= sfrWrData[IRQ0_EDGE_BIT];
		end
	end

	// R4 R5 R22 timer 0 overflow flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) tmr0OvfQ <= 1'h0;
		else if (ovfEv0) tmr0OvfQ <= 1'h1;
		else if (wrCtrl) tmr0OvfQ <= sfrWrData[TMR0_OVF_BIT];
		else if (ackTimer0) tmr0OvfQ <= 1'h0;
	end

	// R1 R2 R22 timer 1 overflow flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) tmr1OvfQ <= 1'h0;
		else if (tmr1FlagSet) tmr1OvfQ <= 1'h1;
		else if (wrCtrl) tmr1OvfQ <= sfrWrData[TMR1_OVF_BIT];
		else if (ackTimer1) tmr1OvfQ <= 1'h0;
	end

	// R13 R14 timer 0 bytes; a write beats a same-cycle count
	// writing one byte does not stop a carry into the other
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt0LoQ <= BYTE_RESET;
		else if (wrLo0) cnt0LoQ <= sfrWrData;
		else if (tick0) cnt0LoQ <= step0.lo;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt0HiQ <= BYTE_RESET;
		else if (wrHi0) cnt0HiQ <= sfrWrData;
		else if (mode0 == MODE_SPLIT) begin
			if (hiTick0) cnt0HiQ <= cnt0HiQ + 8'h01;
		end else if (tick0) cnt0HiQ <= step0.hi;
	end

	// R13 R14 timer 1 bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt1LoQ <= BYTE_RESET;
		else if (wrLo1) cnt1LoQ <= sfrWrData;
		else if (tick1) cnt1LoQ <= step1.lo;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt1HiQ <= BYTE_RESET;
		else if (wrHi1) cnt1HiQ <= sfrWrData;
		else if (tick1) cnt1HiQ <= step1.hi;
	end

	// timer 1 overflow still clocks the serial port when it has no flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) ovfPulseQ <= 1'h0;
		else ovfPulseQ <= ovfEv1;
	end

	// R7 R8 R9 R10 external interrupt detectors
	ext_irq_detect u_irq0 (
		.clk        (clk),
		.rst        (rst),
		.pinLevel   (pinBus.level[PIN_IRQ0]),
		.edgeSelect (irq0EdgeQ),
		.vectorAck  (ackExt0),
		.swWrite    (wrCtrl),
		.swValue    (sfrWrData[IRQ0_FLAG_BIT]),
		.flag       (irq0Flag)
	);

	ext_irq_detect u_irq1 (
		.clk        (clk),
		.rst        (rst),
		.pinLevel   (pinBus.level[PIN_IRQ1]),
		.edgeSelect (irq1EdgeQ),
		.vectorAck  (ackExt1),
		.swWrite    (wrCtrl),
		.swValue    (sfrWrData[IRQ1_FLAG_BIT]),
		.flag       (irq1Flag)
	);

	// registered read; unmapped addresses read zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) rdDataQ <= BYTE_RESET;
		else begin
			case (sfrAddr)
				ADDR_RUN_IRQ_CTRL: rdDataQ <= {tmr1OvfQ, tmr1RunQ, tmr0OvfQ, tmr0RunQ,
					irq1Flag, irq1EdgeQ, irq0Flag, irq0EdgeQ};
				ADDR_MODE_CONFIG:  rdDataQ <= modeCfgQ;
				ADDR_TMR0_LOW:     rdDataQ <= cnt0LoQ;
				ADDR_TMR1_LOW:     rdDataQ <= cnt1LoQ;
				ADDR_TMR0_HIGH:    rdDataQ <= cnt0HiQ;
				ADDR_TMR1_HIGH:    rdDataQ <= cnt1HiQ;
				default:           rdDataQ <= BYTE_RESET;
			endcase
		end
	end

	// outputs straight from flops
	assign sfrRdData      = rdDataQ;
	assign timer0IrqReq   = tmr0OvfQ;
	assign timer1IrqReq   = tmr1OvfQ;
	assign extIrq0Req     = irq0Flag;
	assign extIrq1Req     = irq1Flag;
	assign timer1OvfPulse = ovfPulseQ;

	// R1 overflow sets flag
	property p_tmr1_set;
		@(posedge clk) disable iff (rst) tmr1FlagSet |=> timer1IrqReq;
	endproperty
	a_tmr1_set: assert property (p_tmr1_set) else $error("timer 1 flag not set"); // R1
	// R2 ack clears flag
	property p_tmr1_ack;
		@(posedge clk) disable iff (rst)
			ackTimer1 && !tmr1FlagSet && !wrCtrl |=> !timer1IrqReq;
	endproperty
	a_tmr1_ack: assert property (p_tmr1_ack) else $error("timer 1 flag not cleared"); // R2
	// R3 run bit write
	property p_run1_write;
		@(posedge clk) disable iff (rst)
			wrCtrl |=> tmr1RunQ == $past(sfrWrData[TMR1_RUN_BIT]);
	endproperty
	a_run1_write: assert property (p_run1_write) else $error("timer 1 run bit wrong"); // R3
	// R4 overflow sets flag
	property p_tmr0_set;
		@(posedge clk) disable iff (rst) ovfEv0 |=> timer0IrqReq;
	endproperty
	a_tmr0_set: assert property (p_tmr0_set) else $error("timer 0 flag not set"); // R4
	// R5 ack clears flag
	property p_tmr0_ack;
		@(posedge clk) disable iff (rst)
			ackTimer0 && !ovfEv0 && !wrCtrl |=> !timer0IrqReq;
	endproperty
	a_tmr0_ack: assert property (p_tmr0_ack) else $error("timer 0 flag not cleared"); // R5
	// R6 stopped timer holds
	property p_run0_stop;
		@(posedge clk) disable iff (rst) !tmr0RunQ && !wrLo0 |=> $stable(cnt0LoQ);
	endproperty
	a_run0_stop: assert property (p_run0_stop) else $error("stopped timer 0 moved"); // R6
	// R16 one step per clock
	property p_timer_step;
		@(posedge clk) disable iff (rst)
			mode0 == MODE_16BIT && run0 && !cnt0Sel && !wrLo0
			|=> cnt0LoQ == $past(cnt0LoQ) + 8'h01;
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("timer 0 missed a clock"); // R16
	// R19 gate holds count
	property p_gate_hold;
		@(posedge clk) disable iff (rst)
			gate0 && !pinBus.level[PIN_IRQ0] && !wrLo0 |=> $stable(cnt0LoQ);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gated timer 0 moved"); // R19
	// R20 at most half rate
	property p_count_rate;
		@(posedge clk) disable iff (rst) cntFall[0] |=> !cntFall[0];
	endproperty
	a_count_rate: assert property (p_count_rate) else $error("count input too fast"); // R20
	// R18 reload from high
	property p_reload;
		@(posedge clk) disable iff (rst)
			mode1 == MODE_RELOAD8 && mode0 != MODE_SPLIT && tick1 && !wrLo1
			&& cnt1LoQ == BYTE_FULL |=> cnt1LoQ == $past(cnt1HiQ) && timer1IrqReq;
	endproperty
	a_reload: assert property (p_reload) else $error("reload failed"); // R18
	// R18 timer 1 split holds
	property p_split_hold;
		@(posedge clk) disable iff (rst)
			mode1 == MODE_SPLIT && !wrLo1 && !wrHi1 |=> $stable({cnt1HiQ, cnt1LoQ});
	endproperty
	a_split_hold: assert property (p_split_hold) else $error("timer 1 moved in split"); // R18
	// R21 upper bits untouched
	property p_prescale_top;
		@(posedge clk) disable iff (rst)
			mode0 == MODE_13BIT && !wrLo0
			|=> cnt0LoQ[7:PRESCALE_BITS] == $past(cnt0LoQ[7:PRESCALE_BITS]);
	endproperty
	a_prescale_top: assert property (p_prescale_top) else $error("upper bits changed"); // R21
	// R22 set beats clear
	property p_set_wins;
		@(posedge clk) disable iff (rst)
			wrCtrl && !sfrWrData[TMR1_OVF_BIT] && tmr1FlagSet |=> timer1IrqReq;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat overflow"); // R22
endmodule // dual_timer_control

// ==== rtl/dual_timer_pkg.sv ====
// package: register addresses, bit positions, mode codes for the dual timer
// assumes: an 8-bit special function register space shared with the core
package dual_timer_pkg;

	// register addresses
	localparam logic [7:0] ADDR_RUN_IRQ_CTRL = 8'h88;
	localparam logic [7:0] ADDR_MODE_CONFIG  = 8'h89;
	localparam logic [7:0] ADDR_TMR0_LOW     = 8'h8A;
	localparam logic [7:0] ADDR_TMR1_LOW     = 8'h8B;
	localparam logic [7:0] ADDR_TMR0_HIGH    = 8'h8C;
	localparam logic [7:0] ADDR_TMR1_HIGH    = 8'h8D;

	// byte values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] BYTE_FULL  = 8'hFF;

	// run and irq control register bits
	localparam int TMR1_OVF_BIT  = 7;
	localparam int TMR1_RUN_BIT  = 6;
	localparam int TMR0_OVF_BIT  = 5;
	localparam int TMR0_RUN_BIT  = 4;
	localparam int IRQ1_FLAG_BIT = 3;
	localparam int IRQ1_EDGE_BIT = 2;
	localparam int IRQ0_FLAG_BIT = 1;
	localparam int IRQ0_EDGE_BIT = 0;

	// mode config: one nibble per timer
	localparam int CFG_TMR1_BASE   = 4;
	localparam int CFG_TMR0_BASE   = 0;
	localparam int CFG_GATE_OFS    = 3;
	localparam int CFG_COUNTER_OFS = 2;
	localparam int CFG_MODE_OFS    = 0;

	// width of the low-byte prescaler in the 13-bit mode
	localparam int PRESCALE_BITS = 5;

	// synchronised pin vector layout
	localparam int PIN_COUNT = 4;
	localparam int PIN_IRQ0  = 0;
	localparam int PIN_IRQ1  = 1;
	localparam int PIN_CNT0  = 2;
	localparam int PIN_CNT1  = 3;

	typedef enum logic [1:0] {
		MODE_13BIT   = 2'h0,
		MODE_16BIT   = 2'h1,
		MODE_RELOAD8 = 2'h2,
		MODE_SPLIT   = 2'h3
	} timer_mode_t;

	typedef struct packed {
		logic       ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} count_step_t;

endpackage

// ==== rtl/timer_pins_if.sv ====
// interface: synchronised pin levels from the pin filter to the timer logic
// assumes: a single clock domain on both ends
`timescale 1ns/1ps
interface timer_pins_if #(parameter int WIDTH = 4);
	logic [WIDTH-1:0] level;
	modport source (output level);
	modport sink   (input  level);
endinterface

// ==== rtl/pin_sync.sv ====
// module: three-stage synchroniser with agreement filter per pin
// assumes: pins idle high and are asynchronous to clk
`timescale 1ns/1ps
module pin_sync
	import dual_timer_pkg::*;
#(
	parameter int WIDTH = PIN_COUNT
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// raw pins
	input  wire logic [WIDTH-1:0] pinRaw,
	// filtered levels
	timer_pins_if.source          pins
);
	logic [WIDTH-1:0] levelVec;

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1Q, s2Q, s3Q, levelQ;
		// a change counts only once stages two and three agree
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				s1Q    <= 1'h1;
				s2Q    <= 1'h1;
				s3Q    <= 1'h1;
				levelQ <= 1'h1;
			end else begin
				s1Q <= pinRaw[i];
				s2Q <= s1Q;
				s3Q <= s2Q;
				if (s2Q == s3Q) levelQ <= s3Q;
			end
		end
		assign levelVec[i] = levelQ;
	end

	assign pins.level = levelVec;
endmodule // pin_sync

// ==== rtl/ext_irq_detect.sv ====
// module: edge or level detection and flag for one external interrupt
// assumes: pinLevel already synchronised, ack is a one-cycle pulse
`timescale 1ns/1ps
module ext_irq_detect (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pin and configuration
	input  wire logic pinLevel,
	input  wire logic edgeSelect,
	// vectoring and software access
	input  wire logic vectorAck,
	input  wire logic swWrite,
	input  wire logic swValue,
	// flag
	output logic      flag
);
	logic prevQ, flagQ, falling;

	// R11 one means falling edge
	assign falling = edgeSelect & prevQ & ~pinLevel;

	// previous level for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) prevQ <= 1'h1;
		else prevQ <= pinLevel;
	end

	// R7 R8 R10 flag set source
	// level mode tracks the pin, so software writes have no lasting effect there
	always_ff @(posedge clk or posedge rst) begin
		if (rst) flagQ <= 1'h0;
		else if (!edgeSelect) flagQ <= ~pinLevel;
		else if (falling) flagQ <= 1'h1;  // R22 set beats clear
		else if (swWrite) flagQ <= swValue;
		else if (vectorAck) flagQ <= 1'h0; // R9 edge only
	end

	assign flag = flagQ;

	// R7 edge sets flag
	property p_edge_set;
		@(posedge clk) disable iff (rst) falling |=> flag;
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge did not set flag"); // R7

	// R9 ack clears edge flag
	property p_edge_ack;
		@(posedge clk) disable iff (rst)
			edgeSelect && vectorAck && !falling && !swWrite |=> !flag;
	endproperty
	a_edge_ack: assert property (p_edge_ack) else $error("ack did not clear flag"); // R9

	// R10 level follows pin
	property p_level_follow;
		@(posedge clk) disable iff (rst) !edgeSelect |=> flag == !$past(pinLevel);
	endproperty
	a_level_follow: assert property (p_level_follow) else $error("level flag off"); // R10
endmodule // ext_irq_detect

// ==== testbench/pin_partner.sv ====
// model: external interrupt and count pins on the far side of the timers
// assumes: pins idle high through pull-ups; changes land at falling clk edges
`timescale 1ns/1ps
module pin_partner (
	// clock
	input  wire logic clk,
	// pins toward the block
	output logic      irq0Pin,
	output logic      irq1Pin,
	output logic      cnt0Pin,
	output logic      cnt1Pin
);
	// released pins rest at the pull-up level
	initial begin
		irq0Pin = 1'b1;
		irq1Pin = 1'b1;
		cnt0Pin = 1'b1;
		cnt1Pin = 1'b1;
	end

	task automatic setIrq(input int idx, input logic lvl);
		@(negedge clk);
		if (idx == 0) irq0Pin = lvl;
		else irq1Pin = lvl;
	endtask

	task automatic pulses(input int idx, input int n);
		repeat (n) begin
			if (idx == 0) cnt0Pin = 1'b0;
			else cnt1Pin = 1'b0;
			repeat (2) @(negedge clk);
			if (idx == 0) cnt0Pin = 1'b1;
			else cnt1Pin = 1'b1;
			repeat (2) @(negedge clk);
		end
	endtask
endmodule // pin_partner

// ==== testbench/tb_top.sv ====
// testbench: one task per scenario for the dual timer control block
// assumes: pin_partner drives the pins; inputs change at falling edges
`timescale 1ns/1ps
module tb_top;
	import dual_timer_pkg::*;
	logic       clk;
	logic       rst;
	logic [7:0] sfrAddr;
	logic       sfrWrEn;
	logic [7:0] sfrWrData;
	logic [7:0] sfrRdData;
	logic       ackTimer0, ackTimer1, ackExt0, ackExt1;
	logic       irq0Pin, irq1Pin, cnt0Pin, cnt1Pin;
	logic       timer0IrqReq, timer1IrqReq, extIrq0Req, extIrq1Req;
	logic       timer1OvfPulse;
	logic [3:0] reqs;
	logic [7:0] v;
	int         badCount, testsRun, pulseCount, n;

	assign reqs = {extIrq1Req, extIrq0Req, timer1IrqReq, timer0IrqReq};

	dual_timer_control dut_u (.clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .ackTimer0(ackTimer0),
		.ackTimer1(ackTimer1), .ackExt0(ackExt0), .ackExt1(ackExt1),
		.extIrq0Pin(irq0Pin), .extIrq1Pin(irq1Pin), .timer0CountPin(cnt0Pin),
		.timer1CountPin(cnt1Pin), .timer0IrqReq(timer0IrqReq), .timer1IrqReq(timer1IrqReq),
		.extIrq0Req(extIrq0Req), .extIrq1Req(extIrq1Req), .timer1OvfPulse(timer1OvfPulse));

	pin_partner pins_u (.clk(clk), .irq0Pin(irq0Pin), .irq1Pin(irq1Pin),
		.cnt0Pin(cnt0Pin), .cnt1Pin(cnt1Pin));

	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// baud pulses seen since the last reset
	always @(posedge clk) begin
		if (rst) pulseCount <= 0;
		else if (timer1OvfPulse === 1'b1) pulseCount <= pulseCount + 1;
	end

	task automatic closeOut();
		$display("mismatches %0d of %0d comparisons", badCount, testsRun);
		if (badCount == 0 && testsRun > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
		end
	endtask

	// second and later resets land mid-run on purpose
	task automatic doReset();
		@(negedge clk);
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
	endtask

	// strobe for one edge, then one idle edge so strobes never abut
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		@(negedge clk);
		sfrWrEn = 1'b0;
		@(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfrAddr = a;
		@(negedge clk);
		d = sfrRdData;
	endtask

	// counts edges since the write edge; a hang ends the run
	task automatic waitFor(input int sel, input logic lvl, output int cnt);
		cnt = 1;
		while (reqs[sel] !== lvl && cnt < 30) begin
			@(negedge clk);
			cnt++;
		end
		if (reqs[sel] !== lvl) begin
			check(8'h00, 8'h01, "wait ran out");
			closeOut();
		end
	endtask

	task automatic pulseAck(input int sel);
		{ackExt1, ackExt0, ackTimer1, ackTimer0} = 4'h1 << sel;
		@(negedge clk);
		{ackExt1, ackExt0, ackTimer1, ackTimer0} = 4'h0;
	endtask

	task automatic scResetValues();
		doReset();
		for (int a = 8'h88; a <= 8'h8D; a++) begin
			rd(8'(a), v);
			check(v, BYTE_RESET, "reset value");
		end
		wr(ADDR_TMR0_HIGH, 8'hA5);
		rd(ADDR_TMR0_HIGH, v);
		check(v, 8'hA5, "count byte readback");
		rd(8'h90, v);
		check(v, 8'h00, "unmapped read");
	endtask

	task automatic scTimer16();
		doReset();
		wr(ADDR_MODE_CONFIG, 8'h01);
		wr(ADDR_TMR0_HIGH, BYTE_FULL);
		wr(ADDR_TMR0_LOW, 8'hFD);
		wr(ADDR_RUN_IRQ_CTRL, 8'h15);
		waitFor(0, 1'b1, n);
		check(8'(n), 8'h03, "clocks to overflow");
		check({7'h0, timer0IrqReq}, 8'h01, "t0 flag with edge bits set");
		pulseAck(0);
		check({7'h0, timer0IrqReq}, 8'h00, "t0 flag after ack");
		wr(ADDR_RUN_IRQ_CTRL, 8'h05);
		rd(ADDR_TMR0_LOW, v);
		check(v, 8'h02, "count when stopped");
		repeat (4) @(negedge clk);
		rd(ADDR_TMR0_LOW, v);
		check(v, 8'h02, "count holds while off");
	endtask

	task automatic scTimer13();
		doReset();
		wr(ADDR_TMR0_HIGH, BYTE_FULL);
		wr(ADDR_TMR0_LOW, 8'hFE);
		wr(ADDR_RUN_IRQ_CTRL, 8'h10);
		waitFor(0, 1'b1, n);
		check(8'(n), 8'h02, "13-bit wrap");
		wr(ADDR_RUN_IRQ_CTRL, 8'h00);
		rd(ADDR_TMR0_LOW, v);
		check(v, 8'hE1, "upper low bits kept");
		rd(ADDR_TMR0_HIGH, v);
		check(v, 8'h00, "high byte wrapped");
	endtask

	task automatic scReload();
		doReset();
		wr(ADDR_MODE_CONFIG, 8'h20);
		wr(ADDR_TMR1_HIGH, 8'hF0);
		wr(ADDR_TMR1_LOW, 8'hFE);
		wr(ADDR_RUN_IRQ_CTRL, 8'h40);
		// a clearing write lands on the overflow edge
		wr(ADDR_RUN_IRQ_CTRL, 8'h40);
		waitFor(1, 1'b1, n);
		check(8'(n), 8'h01, "overflow beat clearing write");
		wr(ADDR_RUN_IRQ_CTRL, 8'h80);
		rd(ADDR_TMR1_LOW, v);
		check(v, 8'hF2, "reload from high");
		rd(ADDR_TMR1_HIGH, v);
		check(v, 8'hF0, "high byte unchanged");
		check(8'(pulseCount), 8'h01, "one baud pulse");
		check({7'h0, timer1IrqReq}, 8'h01, "t1 flag still set");
		pulseAck(1);
		check({7'h0, timer1IrqReq}, 8'h00, "t1 flag after ack");
	endtask

	task automatic scSplit();
		doReset();
		wr(ADDR_MODE_CONFIG, 8'h03);
		wr(ADDR_TMR0_HIGH, 8'hFE);
		wr(ADDR_RUN_IRQ_CTRL, 8'h40);
		waitFor(1, 1'b1, n);
		check(8'(n), 8'h02, "split high byte uses t1 flag");
		check({7'h0, timer0IrqReq}, 8'h00, "low half idle");
		// timer 1 in its own split mode holds its count
		wr(ADDR_MODE_CONFIG, 8'h33);
		rd(ADDR_TMR1_LOW, v);
		n = v;
		repeat (4) @(negedge clk);
		rd(ADDR_TMR1_LOW, v);
		check(v, 8'(n), "timer 1 held in split");
	endtask

	task automatic scGateCounter();
		doReset();
		wr(ADDR_MODE_CONFIG, 8'h59);
		pins_u.setIrq(0, 1'b0);
		repeat (8) @(negedge clk);
		wr(ADDR_RUN_IRQ_CTRL, 8'h50);
		repeat (6) @(negedge clk);
		rd(ADDR_TMR0_LOW, v);
		check(v, 8'h00, "gated while pin low");
		pins_u.setIrq(0, 1'b1);
		pins_u.pulses(1, 5);
		repeat (8) @(negedge clk);
		rd(ADDR_TMR0_LOW, v);
		check({7'h0, v != 8'h00}, 8'h01, "counts once pin high");
		rd(ADDR_TMR1_LOW, v);
		check(v, 8'h05, "one count per fall");
	endtask

	task automatic scExtIrq();
		doReset();
		wr(ADDR_RUN_IRQ_CTRL, 8'h05);
		pins_u.setIrq(1, 1'b0);
		repeat (3) @(negedge clk);
		pins_u.setIrq(1, 1'b1);
		waitFor(3, 1'b1, n);
		repeat (8) @(negedge clk);
		check({7'h0, extIrq1Req}, 8'h01, "edge flag latched");
		check({7'h0, extIrq0Req}, 8'h00, "no edge on pin 0");
		pulseAck(3);
		check({7'h0, extIrq1Req}, 8'h00, "edge flag cleared by ack");
		wr(ADDR_RUN_IRQ_CTRL, 8'h00);
		pins_u.setIrq(0, 1'b0);
		waitFor(2, 1'b1, n);
		pulseAck(2);
		check({7'h0, extIrq0Req}, 8'h01, "level flag ignores ack");
		pins_u.setIrq(0, 1'b1);
		waitFor(2, 1'b0, n);
		check({7'h0, extIrq0Req}, 8'h00, "level flag follows pin");
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		sfrAddr = 8'h00;
		sfrWrEn = 1'b0;
		sfrWrData = 8'h00;
		{ackExt1, ackExt0, ackTimer1, ackTimer0} = 4'h0;
		badCount = 0;
		testsRun = 0;
		scResetValues();
		scTimer16();
		scTimer13();
		scReload();
		scSplit();
		scGateCounter();
		scExtIrq();
		closeOut();
	end
endmodule // tb_top
